// ==== common/cits_pkg.sv ====
// Operation
// - opcode 94 loads stack from index minus one
// - opcode 8f clears mask then halts
// - free cycle lasts one clock, reads
// - program fetch advances address by one
// - vector read from top page, high first
// - each stack push is one write cycle
// - branch adds signed offset to next address
// - direct address forces upper byte zero
// - indexed offset is zero extended
// - bit field selects bit zero to seven
package cits_pkg;
    localparam logic [7:0]  OP_IDX_TO_STACK = 8'h94;
    localparam logic [7:0]  OP_WAIT         = 8'h8f;
    localparam logic [7:0]  OP_BRANCH       = 8'h20;
    localparam logic [7:0]  OP_LOAD_IDX_IMM = 8'h45;
    localparam logic [7:0]  OP_LOAD_ACC_IX1 = 8'he6;
    localparam logic [3:0]  OP_BIT_GROUP    = 4'h1;
    localparam logic [15:0] RESET_VEC       = 16'hfffe;
    localparam logic [15:0] IRQ_VEC         = 16'hfff8;
    localparam logic [7:0]  TOP_PAGE        = 8'hff;
    localparam logic [7:0]  DIRECT_PAGE     = 8'h00;
    localparam logic [15:0] SP_RESET        = 16'h00ff;
    localparam logic [15:0] HX_RESET        = 16'h0000;
    localparam logic [7:0]  FLAGS_RESET     = 8'h68;
    localparam int          FLAG_MASK_BIT   = 3;
    localparam logic [2:0]  PUSH_LAST       = 3'h4;

    typedef enum logic [2:0] {
        CYC_FREE,
        CYC_PROG,
        CYC_READ,
        CYC_WRITE,
        CYC_PUSH,
        CYC_POP,
        CYC_VECT
    } cits_cycle_type;

    function automatic logic [15:0] rel_target(input logic [15:0] next_pc, input logic [7:0] off);
        rel_target = 16'(next_pc + {{8{off[7]}}, off});
    endfunction : rel_target

    function automatic logic [15:0] direct_addr(input logic [7:0] off);
        direct_addr = {DIRECT_PAGE, off};
    endfunction : direct_addr

    function automatic logic [15:0] index_addr(input logic [15:0] hx, input logic [7:0] off);
        index_addr = 16'(hx + {8'h00, off});
    endfunction : index_addr

    function automatic logic [7:0] bit_mask(input logic [2:0] n);
        bit_mask = 8'(8'h01 << n);
    endfunction : bit_mask
endpackage : cits_pkg

// ==== hw/cits_core.sv ====
`timescale 1ns/100ps
`default_nettype none
module cits_core
(
    input  wire logic                     sys_clk_i,
    input  wire logic                     arst_n_i,
    input  wire logic                     irq_req_i,
    input  wire logic [7:0]               bus_rdata_i,
    output logic      [15:0]              bus_addr_o,
    output logic      [7:0]               bus_wdata_o,
    output logic                          bus_rd_o,
    output cits_pkg::cits_cycle_type      cycle_type_o,
    output logic                          halted_o,
    output logic      [15:0]              sp_o,
    output logic      [15:0]              hx_o,
    output logic      [7:0]               acc_o,
    output logic      [7:0]               condition_flags_o
);
    typedef enum logic [3:0] {
        ST_VEC_HI, ST_VEC_LO, ST_FETCH, ST_FREE, ST_IMM_HI, ST_IMM_LO, ST_REL,
        ST_DIR, ST_IX_OFF, ST_OPR_RD, ST_OPR_WR, ST_HALT, ST_PUSH
    } cits_state_type;

    cits_state_type state_q;
    logic [15:0]    pc_q;
    logic [15:0]    sp_q;
    logic [15:0]    hx_q;
    logic [15:0]    ea_q;
    logic [15:0]    vec_q;
    logic [7:0]     acc_q;
    logic [7:0]     condition_flags_q;
    logic [7:0]     opcode_q;
    logic [7:0]     data_q;
    logic [2:0]     push_cnt_q;
    logic           wait_q;
    logic           irq_s1_q;
    logic           irq_s2_q;
    logic           bit_op;
    logic           wake;

    assign bit_op = (opcode_q[7:4] == cits_pkg::OP_BIT_GROUP);
    assign wake   = irq_s2_q && !condition_flags_q[cits_pkg::FLAG_MASK_BIT];

    // interrupt request synchroniser
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            irq_s1_q <= 1'b0;
            irq_s2_q <= 1'b0;
        end
        else
        begin
            irq_s1_q <= irq_req_i;
            irq_s2_q <= irq_s1_q;
        end
    end

    // bus cycle presentation
    always_comb
    begin
        bus_addr_o   = pc_q;
        bus_wdata_o  = 8'h00;
        bus_rd_o     = 1'b1;
        cycle_type_o = cits_pkg::CYC_FREE;
        unique case (state_q)
            ST_VEC_HI:
            begin
                bus_addr_o   = vec_q;
                cycle_type_o = cits_pkg::CYC_VECT;
            end
            ST_VEC_LO:
            begin
                bus_addr_o   = 16'(vec_q + 16'h0001);
                cycle_type_o = cits_pkg::CYC_VECT;
            end
            ST_FETCH, ST_IMM_HI, ST_IMM_LO, ST_REL, ST_DIR, ST_IX_OFF:
            begin
                cycle_type_o = cits_pkg::CYC_PROG;
            end
            ST_OPR_RD:
            begin
                bus_addr_o   = ea_q;
                cycle_type_o = cits_pkg::CYC_READ;
            end
            ST_OPR_WR:
            begin
                bus_addr_o   = ea_q;
                bus_rd_o     = 1'b0;
                bus_wdata_o  = data_q;
                cycle_type_o = cits_pkg::CYC_WRITE;
            end
            ST_PUSH:
            begin
                bus_addr_o   = sp_q;
                bus_rd_o     = 1'b0;
                cycle_type_o = cits_pkg::CYC_PUSH;
                unique case (push_cnt_q)
                    3'h0:    bus_wdata_o = pc_q[7:0];
                    3'h1:    bus_wdata_o = pc_q[15:8];
                    3'h2:    bus_wdata_o = hx_q[7:0];
                    3'h3:    bus_wdata_o = acc_q;
                    default: bus_wdata_o = condition_flags_q;
                endcase
            end
            ST_FREE, ST_HALT:
            begin
                cycle_type_o = cits_pkg::CYC_FREE;
            end
        endcase
    end

    // sequencer
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_q    <= ST_VEC_HI;
            opcode_q   <= 8'h00;
            push_cnt_q <= 3'h0;
        end
        else
        begin
            unique case (state_q)
                ST_VEC_HI: state_q <= ST_VEC_LO;
                ST_VEC_LO: state_q <= ST_FETCH;
                ST_FETCH:
                begin
                    if (wait_q)
                        state_q <= ST_HALT;
                    else
                    begin
                        opcode_q <= bus_rdata_i;
                        if (bus_rdata_i == cits_pkg::OP_BRANCH)
                            state_q <= ST_REL;
                        else if (bus_rdata_i == cits_pkg::OP_LOAD_IDX_IMM)
                            state_q <= ST_IMM_HI;
                        else if (bus_rdata_i == cits_pkg::OP_LOAD_ACC_IX1)
                            state_q <= ST_IX_OFF;
                        else if (bus_rdata_i[7:4] == cits_pkg::OP_BIT_GROUP)
                            state_q <= ST_DIR;
                        else
                            state_q <= ST_FREE;
                    end
                end
                ST_FREE:   state_q <= bit_op ? ST_OPR_WR : ST_FETCH;
                ST_IMM_HI: state_q <= ST_IMM_LO;
                ST_IMM_LO: state_q <= ST_FETCH;
                ST_REL:    state_q <= ST_FREE;
                ST_DIR:    state_q <= ST_OPR_RD;
                ST_IX_OFF: state_q <= ST_OPR_RD;
                ST_OPR_RD: state_q <= bit_op ? ST_FREE : ST_FETCH;
                ST_OPR_WR: state_q <= ST_FETCH;
                ST_HALT:
                begin
                    if (wake)
                    begin
                        state_q    <= ST_PUSH;
                        push_cnt_q <= 3'h0;
                    end
                end
                ST_PUSH:
                begin
                    push_cnt_q <= 3'(push_cnt_q + 3'h1);
                    if (push_cnt_q == cits_pkg::PUSH_LAST)
                        state_q <= ST_VEC_HI;
                end
            endcase
        end
    end

    // program counter
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            pc_q <= 16'h0000;
        else if (state_q == ST_VEC_HI)
            pc_q[15:8] <= bus_rdata_i;
        else if (state_q == ST_VEC_LO)
            pc_q[7:0] <= bus_rdata_i;
        else if (state_q == ST_FREE && opcode_q == cits_pkg::OP_BRANCH)
            pc_q <= cits_pkg::rel_target(pc_q, data_q);
        else if ((state_q == ST_FETCH && !wait_q) || state_q == ST_IMM_HI || state_q == ST_IMM_LO ||
                 state_q == ST_REL || state_q == ST_DIR || state_q == ST_IX_OFF)
            pc_q <= 16'(pc_q + 16'h0001);
    end

    // stack pointer, index pair, accumulator
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sp_q  <= cits_pkg::SP_RESET;
            hx_q  <= cits_pkg::HX_RESET;
            acc_q <= 8'h00;
        end
        else
        begin
            if (state_q == ST_FREE && opcode_q == cits_pkg::OP_IDX_TO_STACK)
                sp_q <= 16'(hx_q - 16'h0001);
            else if (state_q == ST_PUSH)
                sp_q <= 16'(sp_q - 16'h0001);
            if (state_q == ST_IMM_HI)
                hx_q[15:8] <= bus_rdata_i;
            else if (state_q == ST_IMM_LO)
                hx_q[7:0] <= bus_rdata_i;
            if (state_q == ST_OPR_RD && opcode_q == cits_pkg::OP_LOAD_ACC_IX1)
                acc_q <= bus_rdata_i;
        end
    end

    // condition flags and wait request
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            condition_flags_q <= cits_pkg::FLAGS_RESET;
            wait_q            <= 1'b0;
        end
        else if (state_q == ST_FREE && opcode_q == cits_pkg::OP_WAIT)
        begin
            condition_flags_q[cits_pkg::FLAG_MASK_BIT] <= 1'b0;
            wait_q                                     <= 1'b1;
        end
        else if (state_q == ST_FETCH && wait_q)
            wait_q <= 1'b0;
        else if (state_q == ST_PUSH && push_cnt_q == cits_pkg::PUSH_LAST)
            condition_flags_q[cits_pkg::FLAG_MASK_BIT] <= 1'b1;
    end

    // operand address, data and vector base
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ea_q   <= 16'h0000;
            data_q <= 8'h00;
            vec_q  <= cits_pkg::RESET_VEC;
        end
        else
        begin
            if (state_q == ST_DIR)
                ea_q <= cits_pkg::direct_addr(bus_rdata_i);
            else if (state_q == ST_IX_OFF)
                ea_q <= cits_pkg::index_addr(hx_q, bus_rdata_i);
            if (state_q == ST_REL || state_q == ST_OPR_RD)
                data_q <= bus_rdata_i;
            else if (state_q == ST_FREE && bit_op)
                data_q <= opcode_q[0] ? (data_q & ~cits_pkg::bit_mask(opcode_q[3:1]))
                                      : (data_q | cits_pkg::bit_mask(opcode_q[3:1]));
            if (state_q == ST_PUSH)
                vec_q <= cits_pkg::IRQ_VEC;
        end
    end

    assign halted_o          = (state_q == ST_HALT);
    assign sp_o              = sp_q;
    assign hx_o              = hx_q;
    assign acc_o             = acc_q;
    assign condition_flags_o = condition_flags_q;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    idx_sp_load_a: assert property (state_q == ST_FREE && opcode_q == cits_pkg::OP_IDX_TO_STACK |=>
        sp_q == 16'($past(hx_q) - 16'h0001) && $stable(condition_flags_q)) else $error("index to stack load wrong");
    idx_sp_length_a: assert property (state_q == ST_FETCH && !wait_q && bus_rdata_i == cits_pkg::OP_IDX_TO_STACK |=>
        cycle_type_o == cits_pkg::CYC_FREE ##1 state_q == ST_FETCH) else $error("index to stack not two cycles");
    wait_halt_a: assert property (state_q == ST_FREE && opcode_q == cits_pkg::OP_WAIT |=>
        !condition_flags_q[cits_pkg::FLAG_MASK_BIT] && cycle_type_o == cits_pkg::CYC_PROG ##1 halted_o)
        else $error("wait did not clear mask and halt");
    free_read_a: assert property (cycle_type_o == cits_pkg::CYC_FREE |-> bus_rd_o)
        else $error("free cycle not a read");
    fetch_step_a: assert property (state_q == ST_FETCH && !wait_q |=> pc_q == 16'($past(bus_addr_o) + 16'h0001))
        else $error("fetch did not advance by one");
    vec_order_a: assert property (state_q == ST_VEC_HI |-> bus_addr_o[15:8] == cits_pkg::TOP_PAGE ##1
        (state_q == ST_VEC_LO && bus_addr_o == 16'($past(bus_addr_o) + 16'h0001))) else $error("vector order wrong");
    push_write_a: assert property (cycle_type_o == cits_pkg::CYC_PUSH |-> !bus_rd_o && bus_addr_o == sp_q ##1
        sp_q == 16'($past(sp_q) - 16'h0001)) else $error("push not a single write");
    rel_target_a: assert property (state_q == ST_FREE && opcode_q == cits_pkg::OP_BRANCH |=>
        pc_q == cits_pkg::rel_target($past(pc_q), $past(data_q))) else $error("branch target wrong");
    direct_page_a: assert property (state_q == ST_OPR_RD && bit_op |-> bus_addr_o[15:8] == cits_pkg::DIRECT_PAGE)
        else $error("direct address off page zero");
    ix_offset_a: assert property (state_q == ST_IX_OFF |=>
        ea_q == 16'($past(hx_q) + {8'h00, $past(bus_rdata_i)})) else $error("indexed offset not zero extended");
    bit_select_a: assert property (state_q == ST_OPR_WR && bit_op |->
        ((bus_wdata_o ^ $past(data_q)) & ~cits_pkg::bit_mask(opcode_q[3:1])) == 8'h00 &&
        (bus_wdata_o & cits_pkg::bit_mask(opcode_q[3:1])) ==
        (opcode_q[0] ? 8'h00 : cits_pkg::bit_mask(opcode_q[3:1]))) else $error("bit field wrong");
    wake_stack_a: assert property (halted_o && wake |=>
        cycle_type_o == cits_pkg::CYC_PUSH [*5] ##1 cycle_type_o == cits_pkg::CYC_VECT) else $error("wake sequence wrong");

    idx_sp_seen_c: cover property (state_q == ST_FREE && opcode_q == cits_pkg::OP_IDX_TO_STACK);
    wake_seen_c: cover property (halted_o ##1 state_q == ST_PUSH);
    branch_seen_c: cover property (state_q == ST_FREE && opcode_q == cits_pkg::OP_BRANCH);
    bit_write_c: cover property (state_q == ST_OPR_WR && bit_op);
endmodule : cits_core
`default_nettype wire

// ==== verif/cits_mem_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// zero wait state memory holding the test program; writes land at the end of a write cycle
module cits_mem_model
(
    input  wire logic        sys_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic [15:0] bus_addr_i,
    input  wire logic [7:0]  bus_wdata_i,
    input  wire logic        bus_rd_i,
    output logic      [7:0]  bus_rdata_o
);
    logic [7:0] mem_q [0:65535];

    initial
    begin
        for (int i = 0; i < 65536; i++) mem_q[i] = 8'h00;
        mem_q[16'hfffe] = 8'h01;
        mem_q[16'hfff8] = 8'h02;
        mem_q[16'h0100] = 8'h45;
        mem_q[16'h0101] = 8'h12;
        mem_q[16'h0102] = 8'h34;
        mem_q[16'h0103] = 8'h94;
        mem_q[16'h0104] = 8'he6;
        mem_q[16'h0105] = 8'hf0;
        for (int n = 0; n < 8; n++)
        begin
            mem_q[16'h0106 + 2 * n] = 8'(8'h10 + 2 * n);
            mem_q[16'h0107 + 2 * n] = 8'(8'h40 + n);
        end
        mem_q[16'h0116] = 8'h13;
        mem_q[16'h0117] = 8'h50;
        mem_q[16'h0118] = 8'h20;
        mem_q[16'h0119] = 8'h7f;
        mem_q[16'h0199] = 8'h20;
        mem_q[16'h019a] = 8'h80;
        mem_q[16'h011b] = 8'h8f;
        mem_q[16'h0200] = 8'h20;
        mem_q[16'h0201] = 8'hfe;
        mem_q[16'h1324] = 8'ha5;
        mem_q[16'h0050] = 8'hff;
    end

    always @(posedge sys_clk_i)
        if (arst_n_i && !bus_rd_i) mem_q[bus_addr_i] <= bus_wdata_i;

    // the data line carries the inverted stored byte during write cycles
    assign bus_rdata_o = bus_rd_i ? mem_q[bus_addr_i] : ~mem_q[bus_addr_i];
endmodule : cits_mem_model
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic                     sys_clk = 1'b0;
    logic                     arst_n  = 1'b0;
    logic                     irq_req = 1'b0;
    logic [7:0]               rdata;
    logic [15:0]              addr;
    logic [7:0]               wdata;
    logic                     rd;
    cits_pkg::cits_cycle_type ctype;
    logic                     halted;
    logic [15:0]              sp;
    logic [15:0]              hx;
    logic [7:0]               acc;
    logic [7:0]               flags;
    int                       err_count = 0;
    int                       tests_run = 0;

    always #4 sys_clk = ~sys_clk;

    cits_core cits_core_inst (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .irq_req_i(irq_req), .bus_rdata_i(rdata),
        .bus_addr_o(addr), .bus_wdata_o(wdata), .bus_rd_o(rd), .cycle_type_o(ctype), .halted_o(halted),
        .sp_o(sp), .hx_o(hx), .acc_o(acc), .condition_flags_o(flags));

    cits_mem_model cits_mem_model_inst (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .bus_addr_i(addr),
        .bus_wdata_i(wdata), .bus_rd_i(rd), .bus_rdata_o(rdata));

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask : chk

    task automatic step();
        @(negedge sys_clk);
    endtask : step

    // bounded wait for a cycle of the given type at the given address
    task automatic wait_for(input cits_pkg::cits_cycle_type t, input logic [15:0] a);
        int n;
        n = 0;
        while (!(ctype === t && addr === a) && n < 400)
        begin
            step();
            n++;
        end
        tests_run++;
        if (n >= 400)
        begin
            $display("unexpected cycle at %h expected type %0d seen none", a, t);
            err_count++;
            final_report();
        end
    endtask : wait_for

    task automatic cyc(input cits_pkg::cits_cycle_type t, input logic [15:0] a, input logic r);
        chk("cycle type", 16'(t), 16'(ctype));
        chk("address", a, addr);
        chk("read strobe", 16'(r), 16'(rd));
        step();
    endtask : cyc

    task automatic run_reset_vector();
        cyc(cits_pkg::CYC_VECT, 16'hfffe, 1'b1);
        cyc(cits_pkg::CYC_VECT, 16'hffff, 1'b1);
        chk("fetch after vector", 16'h0100, addr);
    endtask : run_reset_vector

    task automatic run_fetch_and_transfer();
        cyc(cits_pkg::CYC_PROG, 16'h0100, 1'b1);
        cyc(cits_pkg::CYC_PROG, 16'h0101, 1'b1);
        cyc(cits_pkg::CYC_PROG, 16'h0102, 1'b1);
        cyc(cits_pkg::CYC_PROG, 16'h0103, 1'b1);
        chk("index pair", 16'h1234, hx);
        cyc(cits_pkg::CYC_FREE, 16'h0104, 1'b1);
        cyc(cits_pkg::CYC_PROG, 16'h0104, 1'b1);
        chk("stack pointer", 16'h1233, sp);
        chk("flags after transfer", 16'h0068, 16'(flags));
    endtask : run_fetch_and_transfer

    task automatic run_indexed();
        wait_for(cits_pkg::CYC_READ, 16'h1324);
        step();
        chk("accumulator", 16'h00a5, 16'(acc));
    endtask : run_indexed

    task automatic run_bit_ops();
        for (int n = 0; n < 8; n++)
        begin
            wait_for(cits_pkg::CYC_WRITE, 16'(16'h0040 + n));
            chk("bit set data", 16'(8'h01 << n), 16'(wdata));
            chk("write strobe", 16'h0000, 16'(rd));
        end
        wait_for(cits_pkg::CYC_WRITE, 16'h0050);
        chk("bit clear data", 16'h00fd, 16'(wdata));
    endtask : run_bit_ops

    task automatic run_branches();
        wait_for(cits_pkg::CYC_PROG, 16'h0119);
        step();
        cyc(cits_pkg::CYC_FREE, 16'h011a, 1'b1);
        cyc(cits_pkg::CYC_PROG, 16'h0199, 1'b1);
        cyc(cits_pkg::CYC_PROG, 16'h019a, 1'b1);
        step();
        chk("backward target", 16'h011b, addr);
    endtask : run_branches

    task automatic run_wait_and_wake();
        logic [7:0] stacked [5];
        stacked = '{8'h1c, 8'h01, 8'h34, 8'ha5, 8'h60};
        wait_for(cits_pkg::CYC_PROG, 16'h011b);
        step();
        step();
        chk("mask cleared", 16'h0000, 16'(flags[cits_pkg::FLAG_MASK_BIT]));
        step();
        for (int i = 0; i < 10; i++)
        begin
            chk("halted", 16'h0001, 16'(halted));
            cyc(cits_pkg::CYC_FREE, 16'h011c, 1'b1);
        end
        irq_req = 1'b1;
        wait_for(cits_pkg::CYC_PUSH, 16'h1233);
        for (int i = 0; i < 5; i++)
        begin
            chk("pushed byte", 16'(stacked[i]), 16'(wdata));
            cyc(cits_pkg::CYC_PUSH, 16'(16'h1233 - i), 1'b0);
        end
        irq_req = 1'b0;
        cyc(cits_pkg::CYC_VECT, 16'hfff8, 1'b1);
        cyc(cits_pkg::CYC_VECT, 16'hfff9, 1'b1);
        cyc(cits_pkg::CYC_PROG, 16'h0200, 1'b1);
        chk("mask set", 16'h0001, 16'(flags[cits_pkg::FLAG_MASK_BIT]));
        chk("resumed", 16'h0000, 16'(halted));
    endtask : run_wait_and_wake

    initial
    begin
        repeat (2) @(negedge sys_clk);
        arst_n = 1'b1;
        run_reset_vector();
        run_fetch_and_transfer();
        run_indexed();
        run_bit_ops();
        run_branches();
        run_wait_and_wake();
        final_report();
    end
endmodule : tb
`default_nettype wire
